// >>> ssr_pkg.sv
// Shared constants and types for the strap and indirect register slice.
// Assumes one 40 MHz core clock on each end and a serial management link.
package ssr_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;     // Core clock period
  localparam int FLD_WINDOW_NS = 10000;  // Fast link down window, 10 us
  // Longest time rounds down to whole cycles
  localparam int FLD_WINDOW_CYC = FLD_WINDOW_NS / CLK_PERIOD_NS;
  localparam int MDC_DIV_LOG2 = 4;       // Management clock = core / 16

  // ------------------------------------------------------------
  // Management frame layout
  // ------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;  // Ones before start
  localparam logic [3:0] HDR_LAST     = 4'hc;   // 13 header bits
  localparam logic [4:0] WR_LAST      = 5'h11;  // 2 turnaround + 16 data
  localparam logic [4:0] RD_LAST      = 5'h10;  // 16 data, then release
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [4:0] PHY_ADDR     = 5'h01;  // Station address
  localparam logic [5:0] HOST_TA_BIT  = 6'h2e;  // First turnaround bit
  localparam logic [5:0] HOST_RD_BIT  = 6'h30;  // First read data bit
  localparam logic [5:0] HOST_LAST    = 6'h3f;  // Last frame bit

  // ------------------------------------------------------------
  // Device register map and fields
  // ------------------------------------------------------------
  localparam logic [4:0] OFF_STRAP1 = 5'h09;  // soft_strap_first
  localparam logic [4:0] OFF_STRAP3 = 5'h0b;  // soft_strap_third
  localparam logic [4:0] OFF_IACR   = 5'h0d;  // indirect_access_control
  localparam logic [4:0] OFF_IADR   = 5'h0e;  // indirect_address_data
  localparam int CFG_DONE_BIT  = 15;
  localparam int POL_SWAP_BIT  = 6;
  localparam int PAIR_SWAP_BIT = 5;
  localparam int BYPASS_BIT    = 4;
  localparam logic [6:0]  STRAP3_RST = 7'h00;
  localparam logic [15:0] STRAP1_RST = 16'h0000;
  localparam logic [4:0]  EXT_TARGET_DEVICE_FIELD  = 5'h1f;  // Only accepted target
  localparam logic [1:0]  FN_ADDR    = 2'h0;
  localparam logic [1:0]  FN_DATA    = 2'h1;
  localparam logic [1:0]  FN_INC_RW  = 2'h2;
  localparam logic [1:0]  FN_INC_WR  = 2'h3;
  localparam int EXT_DEPTH = 32;               // Extended words held

  // ------------------------------------------------------------
  // Fast link down thresholds
  // ------------------------------------------------------------
  localparam logic [5:0] RECEIVE_ERROR_PIN_LIMIT = 6'h20;  // 32 events
  localparam logic [4:0] MLT3_LIMIT  = 5'h14;  // 20 events
  localparam logic [4:0] SNR_LIMIT   = 5'h14;  // 20 events

  // ------------------------------------------------------------
  // Host register map (APB byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] HOFF_CMD    = 8'h00;
  localparam logic [7:0] HOFF_STATUS = 8'h04;
  localparam logic [7:0] HOFF_RDATA  = 8'h08;

  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_PRE = 3'b000, DS_HDR = 3'b001, DS_WR = 3'b010,
    DS_TA  = 3'b011, DS_RD  = 3'b100
  } ssr_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_WAIT = 2'b01, HS_RUN = 2'b10
  } ssr_host_state_t;

endpackage

// >>> ssr_smi_if.sv
// Serial management link between the station controller and the device.
// Assumes an external pull-up: an undriven data line reads as one.
interface ssr_smi_if;

  // ------------------------------------------------------------
  // Link signals
  // ------------------------------------------------------------
  logic mdc;           // Management clock, made by the host
  logic host_mdio_o;   // Host data out
  logic host_mdio_oe;  // Host drives data line
  logic dev_mdio_o;    // Device data out
  logic dev_mdio_oe;   // Device drives data line
  logic mdio_in;       // Resolved line level

  // Resolve the shared line; pull-up when nobody drives
  assign mdio_in = host_mdio_oe ? host_mdio_o :
                   (dev_mdio_oe ? dev_mdio_o : 1'b1);

  modport host (output mdc, output host_mdio_o, output host_mdio_oe,
                input mdio_in);
  modport dev  (input mdc, input mdio_in, output dev_mdio_o,
                output dev_mdio_oe);

endinterface

// >>> ssr_sync.sv
// Three-stage input synchroniser, one lane per bit.
// Assumes inputs change slowly against core_clk; a level is accepted
// once the second and third stages agree.
module ssr_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ------------------------------------------------------------
  // Per-bit stages
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic s1_q;  // Metastable stage, read only by s2_q
      logic s2_q;
      logic s3_q;
      // Shift and accept on agreement
      always_ff @(posedge core_clk) begin
        if (reset) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            q[i] <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule

// >>> ssr_dev.sv
// Device end: management slave with strap and indirect register slice,
// strap latching and fast link down detection.
// Assumes the management clock is slow against core_clk (>= 16x).
//
// Summary of operation
// R01 - Config done latches straps, pulses internal reset
// R02 - Strap bits 15:7 read zero, ignore writes
// R03 - Bit 6 inverts both pair polarities
// R04 - Bit 5 swaps transmit and receive pairs
// R05 - Port mirror needs bits 5 and 6
// R06 - Bit 4 bypasses 4B/5B, fifth bit on pins
// R07 - Host selects MII mode before bypass
// R08 - 32 receive errors in 10us drop link
// R09 - 20 MLT3 violations in 10us drop link
// R10 - 20 low SNR crossings in 10us drop link
// R11 - Energy loss drops link when enabled
// R12 - Any enabled condition drops the link
// R13 - Extended set reached only via 0x0D/0x0E
// R14 - Function 00 write loads the pointer
// R15 - Host loads pointer before data access
// R16 - Function 01 accesses data, pointer kept
// R17 - Function 10 increments after read and write
// R18 - Function 11 increments after writes only
// R19 - Target field must be 11111, else ignored
// R20 - Pointer wraps 16 bits; ignored reads zero
//
// Register access over APB is this design's own decision.
module ssr_dev (
  input  wire logic core_clk,
  input  wire logic reset,
  ssr_smi_if.dev    smi,
  input  wire logic rx_err_evt,      // Receive error, one per cycle
  input  wire logic mlt3_err_evt,    // MLT3 violation event
  input  wire logic low_snr_evt,     // SNR threshold crossing event
  input  wire logic energy_loss,     // Energy detector reports loss
  input  wire logic tdi_pin,         // Test data in pin
  input  wire logic rx_sym_bit4,     // Fifth received symbol bit
  output logic      link_drop,       // Link drop request; one cycle per count hit, held while energy_loss
  output logic      pol_invert,      // Invert both pair polarities
  output logic      pair_swap,       // Swap transmit/receive pairs
  output logic      port_mirror,     // Port mirror enabled
  output logic      bypass_4b5b,     // 4B/5B coder bypassed
  output logic      tx_sym_bit4,     // Fifth transmit symbol bit
  output logic      receive_error_pin,
  output logic      strap_reset      // Internal reset pulse
);
  import ssr_pkg::*;

  // ------------------------------------------------------------
  // Link sampling
  // ------------------------------------------------------------
  logic [1:0] lnk_s;     // Synchronised {mdc, mdio}
  logic       mdc_l_q;   // Previous synchronised clock
  wire        mdc_rise = lnk_s[1] & ~mdc_l_q;
  wire        bit_in   = lnk_s[0];

  ssr_sync #(.W(2)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .d        ({smi.mdc, smi.mdio_in}),
    .q        (lnk_s)
  );

  // ------------------------------------------------------------
  // Frame state
  // ------------------------------------------------------------
  ssr_dev_state_t st_q;
  logic [5:0]  ones_q;   // Preamble ones seen
  logic [4:0]  cnt_q;    // Bit count inside a phase
  logic [12:0] hdr_q;    // Start, opcode, address fields
  logic [15:0] sh_q;     // Write data in / read data out
  logic [4:0]  reg_q;    // Register addressed by the frame
  logic        oe_q;     // Device drives the line
  logic        out_q;    // Device line value

  wire [12:0] hdr_nx  = {hdr_q[11:0], bit_in};
  wire        hdr_end = (st_q == DS_HDR) && (cnt_q[3:0] == HDR_LAST);
  wire        addr_ok = hdr_nx[12] && (hdr_nx[9:5] == PHY_ADDR);
  wire        is_rd   = addr_ok && (hdr_nx[11:10] == OP_READ);
  wire        is_wr   = addr_ok && (hdr_nx[11:10] == OP_WRITE);
  wire [15:0] wdata   = {sh_q[14:0], bit_in};
  wire        wr_end  = (st_q == DS_WR) && (cnt_q == WR_LAST);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0] strap1_q;     // soft_strap_first, done bit self-clears
  logic [6:0]  strap3_q;     // soft_strap_third as programmed
  logic [6:0]  strap_lat_q;  // Values in force after config done
  logic [1:0]  func_q;       // Indirect function select
  logic [4:0]  target_device_field_q;      // target_device_field
  logic [15:0] ptr_q;        // Extended address pointer
  logic [15:0] ext_mem [EXT_DEPTH];  // Extended register words

  // Indirect decode; only the extended target is served [R19]
  wire ind_ok   = (target_device_field_q == EXT_TARGET_DEVICE_FIELD);
  wire ind_data = ind_ok && (func_q != FN_ADDR);
  wire [4:0] ext_idx = ptr_q[4:0];  // Upper pointer bits alias

  // Access strobes on a frame's data register
  wire rd_iadr = mdc_rise && hdr_end && is_rd && (hdr_nx[4:0] == OFF_IADR);
  wire wr_hit  = mdc_rise && wr_end;
  wire wr_iadr = wr_hit && (reg_q == OFF_IADR);
  // Pointer load only in address function [R14]
  wire ptr_load = wr_iadr && ind_ok && (func_q == FN_ADDR);
  // Post increment: 10 on both, 11 on writes, 01 never [R16] [R17] [R18]
  wire ptr_inc  = (rd_iadr && ind_data && (func_q == FN_INC_RW)) ||
                  (wr_iadr && ind_data && func_q[1]);
  wire cfg_done = wr_hit && (reg_q == OFF_STRAP1) && wdata[CFG_DONE_BIT];

  // Read mux; unmapped and ignored reads return zero [R02] [R20]
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    if (hdr_nx[4:0] == OFF_STRAP1) begin
      rd_val = {1'b0, strap1_q[14:0]};
    end else if (hdr_nx[4:0] == OFF_STRAP3) begin
      rd_val = {9'h000, strap3_q};  // [R02]
    end else if (hdr_nx[4:0] == OFF_IACR) begin
      rd_val = {func_q, 9'h000, target_device_field_q};
    end else if (hdr_nx[4:0] == OFF_IADR && ind_ok) begin
      // Extended set only through this window [R13]
      rd_val = (func_q == FN_ADDR) ? ptr_q : ext_mem[ext_idx];
    end
  end

  // ------------------------------------------------------------
  // Frame receiver and responder
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q    <= DS_PRE;
      ones_q  <= 6'h00;
      cnt_q   <= 5'h00;
      hdr_q   <= 13'h0000;
      sh_q    <= 16'h0000;
      reg_q   <= 5'h00;
      oe_q    <= 1'b0;
      out_q   <= 1'b1;
      mdc_l_q <= 1'b0;
    end else begin
      mdc_l_q <= lnk_s[1];
      if (mdc_rise) begin
        cnt_q <= cnt_q + 5'h01;
        case (st_q)
          DS_PRE: begin
            // Count ones; a zero after a full preamble starts a frame
            cnt_q <= 5'h00;
            if (bit_in) begin
              ones_q <= (ones_q == PREAMBLE_LEN) ? ones_q : ones_q + 6'h01;
            end else begin
              ones_q <= 6'h00;
              if (ones_q == PREAMBLE_LEN) begin
                st_q <= DS_HDR;
              end
            end
          end
          DS_HDR: begin
            hdr_q <= hdr_nx;
            if (hdr_end) begin
              cnt_q <= 5'h00;
              reg_q <= hdr_nx[4:0];
              sh_q  <= rd_val;
              // Other station addresses get no answer
              st_q  <= is_rd ? DS_TA : (is_wr ? DS_WR : DS_PRE);
            end
          end
          DS_WR: begin
            sh_q <= wdata;
            if (wr_end) begin
              st_q <= DS_PRE;
            end
          end
          DS_TA: begin
            // Second turnaround bit is driven low
            oe_q  <= 1'b1;
            out_q <= 1'b0;
            cnt_q <= 5'h00;
            st_q  <= DS_RD;
          end
          DS_RD: begin
            out_q <= sh_q[15];
            sh_q  <= {sh_q[14:0], 1'b0};
            if (cnt_q == RD_LAST) begin
              oe_q  <= 1'b0;
              out_q <= 1'b1;
              st_q  <= DS_PRE;
            end
          end
          default: st_q <= DS_PRE;
        endcase
      end
    end
  end

  assign smi.dev_mdio_o  = out_q;
  assign smi.dev_mdio_oe = oe_q;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Control registers; reserved strap bits are dropped [R02]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap1_q <= STRAP1_RST;
      strap3_q <= STRAP3_RST;
      func_q   <= FN_ADDR;
      target_device_field_q  <= 5'h00;
    end else if (wr_hit) begin
      if (reg_q == OFF_STRAP1) begin
        strap1_q <= {1'b0, wdata[14:0]};  // Done bit never stored
      end else if (reg_q == OFF_STRAP3) begin
        strap3_q <= wdata[6:0];  // [R02]
      end else if (reg_q == OFF_IACR) begin
        func_q  <= wdata[15:14];
        target_device_field_q <= wdata[4:0];
      end
    end
  end

  // Pointer: load, or step by one with 16-bit wrap [R14] [R20]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptr_q <= 16'h0000;
    end else if (ptr_load) begin
      ptr_q <= wdata;
    end else if (ptr_inc) begin
      ptr_q <= ptr_q + 16'h0001;  // [R20]
    end
  end

  // Extended words; data functions only, at the old pointer [R16]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < EXT_DEPTH; i++) begin
        ext_mem[i] <= 16'h0000;
      end
    end else if (wr_iadr && ind_data) begin
      ext_mem[ext_idx] <= wdata;
    end
  end

  // ------------------------------------------------------------
  // Strap latch and internal reset
  // ------------------------------------------------------------
  // Programmed values take effect only at config done [R01]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_lat_q <= STRAP3_RST;
      strap_reset <= 1'b0;
    end else begin
      strap_reset <= cfg_done;  // [R01]
      if (cfg_done) begin
        strap_lat_q <= strap3_q;  // [R01]
      end
    end
  end

  assign pol_invert  = strap_lat_q[POL_SWAP_BIT];   // [R03]
  assign pair_swap   = strap_lat_q[PAIR_SWAP_BIT];  // [R04]
  // Mirror only with both swap bits set [R05]
  assign port_mirror = strap_lat_q[POL_SWAP_BIT] &
                       strap_lat_q[PAIR_SWAP_BIT];
  // MII mode is the host's duty; no RMII check here [R07]
  assign bypass_4b5b = strap_lat_q[BYPASS_BIT];

  // Fifth symbol bits share test and error pins in bypass [R06]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_sym_bit4       <= 1'b0;
      receive_error_pin <= 1'b0;
    end else begin
      tx_sym_bit4       <= bypass_4b5b ? tdi_pin : 1'b0;  // [R06]
      receive_error_pin <= bypass_4b5b ? rx_sym_bit4 : rx_err_evt;
    end
  end

  // ------------------------------------------------------------
  // Fast link down
  // ------------------------------------------------------------
  logic [15:0] win_q;  // Window cycle counter
  logic [5:0]  rxe_q;  // Receive errors this window
  logic [4:0]  mlt_q;  // MLT3 violations this window
  logic [4:0]  snr_q;  // Low SNR crossings this window
  wire  [3:0]  fld_en  = strap_lat_q[3:0];
  wire         win_end = (win_q == 16'(FLD_WINDOW_CYC - 1));
  wire  [5:0]  rxe_nx  = rxe_q + {5'h00, rx_err_evt};
  wire  [4:0]  mlt_nx  = mlt_q + {4'h0, mlt3_err_evt};
  wire  [4:0]  snr_nx  = snr_q + {4'h0, low_snr_evt};
  // Counts saturate; only the event that reaches a limit drops the link,
  // so a saturated count cannot hold the drop high for the whole window
  wire hit_rxe = fld_en[3] && rx_err_evt && (rxe_nx == RECEIVE_ERROR_PIN_LIMIT);  // [R08]
  wire hit_mlt = fld_en[2] && mlt3_err_evt && (mlt_nx == MLT3_LIMIT); // [R09]
  wire hit_snr = fld_en[1] && low_snr_evt && (snr_nx == SNR_LIMIT);  // [R10]
  wire hit_nrg = fld_en[0] && energy_loss;              // [R11]

  // Window and counters; the strap reset restarts the window
  always_ff @(posedge core_clk) begin
    if (reset || strap_reset || win_end) begin
      win_q <= 16'h0000;
      rxe_q <= 6'h00;
      mlt_q <= 5'h00;
      snr_q <= 5'h00;
    end else begin
      win_q <= win_q + 16'h0001;
      rxe_q <= (rxe_q == RECEIVE_ERROR_PIN_LIMIT) ? rxe_q : rxe_nx;
      mlt_q <= (mlt_q == MLT3_LIMIT) ? mlt_q : mlt_nx;
      snr_q <= (snr_q == SNR_LIMIT) ? snr_q : snr_nx;
    end
  end

  // Any enabled source drops the link [R12]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_drop <= 1'b0;
    end else begin
      link_drop <= hit_rxe | hit_mlt | hit_snr | hit_nrg;  // [R12]
    end
  end

endmodule

// >>> ssr_host.sv
// Station management end: APB slave that runs one management frame per
// command and returns read data.
// Assumes a single APB master on core_clk and one device on the link.
module ssr_host (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  ssr_smi_if.host          smi
);
  import ssr_pkg::*;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  ssr_host_state_t st_q;
  logic [MDC_DIV_LOG2-1:0] div_q;  // Management clock divider
  logic [63:0] frame_q;            // Frame bits, msb first
  logic [5:0]  bit_q;              // Frame bit in flight
  logic        rd_q;               // Frame is a read
  logic [15:0] rdata_q;            // Collected read data
  logic        done_q;             // Sticky frame complete
  logic        oe_q;
  logic        mdio_s;             // Synchronised data line

  wire busy    = (st_q != HS_IDLE);
  wire sel_cmd = (paddr[7:0] == HOFF_CMD);
  wire sel_sts = (paddr[7:0] == HOFF_STATUS);
  wire sel_rd  = (paddr[7:0] == HOFF_RDATA);
  wire mapped  = (paddr[31:8] == 24'h000000) && (sel_cmd | sel_sts | sel_rd);
  wire acc     = psel & penable & pready;  // Transfer completes
  wire start   = acc & pwrite & sel_cmd & mapped & ~busy;
  wire done_cl = acc & pwrite & sel_sts & mapped & pwdata[1];
  wire rise    = (div_q == {1'b0, {(MDC_DIV_LOG2-1){1'b1}}});
  wire fall    = (div_q == {MDC_DIV_LOG2{1'b1}});
  wire last    = busy && fall && (st_q == HS_RUN) && (bit_q == HOST_LAST);
  wire [31:0] rd_mux = sel_sts ? {30'h0, done_q, busy} :
                       (sel_rd ? {16'h0000, rdata_q} : 32'h0);

  // One wait state, then a registered answer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & ~pwrite & mapped) ? rd_mux : 32'h0;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // Sticky done; a new completion beats a clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (last) begin
      done_q <= 1'b1;
    end else if (done_cl) begin
      done_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Link engine
  // ------------------------------------------------------------
  ssr_sync #(.W(1)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .d        (smi.mdio_in),
    .q        (mdio_s)
  );

  // Free-running divider; frames start on a falling edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Shift out frame; release line for read turnaround
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q    <= HS_IDLE;
      frame_q <= {2{32'hffffffff}};  // Idle level, no change at start
      bit_q   <= 6'h00;
      rd_q    <= 1'b0;
      oe_q    <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      if (start) begin
        rd_q    <= ~pwdata[21];
        frame_q <= {32'hffffffff, 2'b01,
                    pwdata[21] ? OP_WRITE : OP_READ, PHY_ADDR,
                    pwdata[20:16], pwdata[21] ? 2'b10 : 2'b11,
                    pwdata[21] ? pwdata[15:0] : 16'hffff};
        st_q    <= HS_WAIT;
      end else if (fall && st_q == HS_WAIT) begin
        st_q  <= HS_RUN;
        bit_q <= 6'h00;
        oe_q  <= 1'b1;
      end else if (fall && st_q == HS_RUN) begin
        frame_q <= {frame_q[62:0], 1'b1};
        bit_q   <= bit_q + 6'h01;
        oe_q    <= ~(rd_q && (bit_q + 6'h01 >= HOST_TA_BIT));
        if (last) begin
          st_q <= HS_IDLE;
          oe_q <= 1'b0;
        end
      end
      if (rise && st_q == HS_RUN && rd_q && bit_q >= HOST_RD_BIT) begin
        rdata_q <= {rdata_q[14:0], mdio_s};
      end
    end
  end

  assign smi.mdc          = div_q[MDC_DIV_LOG2-1];
  assign smi.host_mdio_o  = frame_q[63];
  assign smi.host_mdio_oe = oe_q;

endmodule

// >>> ssr_props.sv
// Checker for the management wire between host end and device end.
// Assumes one core clock; instantiated beside the link interface.
module ssr_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic host_mdio_o,
  input wire logic host_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic mdio_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Halves of the divided management clock
  sequence hi_half; mdc [*8]; endsequence
  sequence lo_half; !mdc [*8]; endsequence
  chk_mdc_period: assert property ($rose(mdc) |-> hi_half ##1 lo_half)
    else $error("mdc period wrong");
  chk_no_contention: assert property (!(host_mdio_oe && dev_mdio_oe))
    else $error("both ends drive");
  chk_idle_high: assert property (!host_mdio_oe && !dev_mdio_oe |-> mdio_in)
    else $error("idle line not high");
  chk_host_setup: assert property ($rose(mdc) && host_mdio_oe |-> $stable(host_mdio_o))
    else $error("host data moves at rise");
  chk_dev_setup: assert property ($rose(mdc) && dev_mdio_oe |-> $stable(dev_mdio_o))
    else $error("device data moves at rise");
  chk_preamble_ones: assert property ($rose(host_mdio_oe) |-> mdio_in [*8])
    else $error("preamble not ones");
  chk_ta_low: assert property ($rose(dev_mdio_oe) |-> ##[0:2] !mdio_in)
    else $error("turnaround not low");
  chk_host_on_low: assert property ($changed(host_mdio_o) |-> !mdc)
    else $error("host data moved while mdc high");
endmodule

// >>> test_soft_strap_and_indirect_regs.sv
// Bench: APB drives the host end, the device end answers over the link.
// Assumes both ends share a 40 MHz core clock.
module test_soft_strap_and_indirect_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import ssr_pkg::*;
  logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, link_drop, pol_invert, pair_swap, port_mirror;
  logic bypass_4b5b, tx_sym_bit4, receive_error_pin, strap_reset;
  logic [2:0] ev = 3'h0;  // Receive error, MLT3, low SNR events
  logic energy_loss = 0, tdi_pin = 0;
  int fail_count = 0, checks_done = 0, srst_n = 0;
  always #12.5 core_clk = ~core_clk;
  // Count internal reset pulses seen
  always @(negedge core_clk) srst_n += strap_reset;
  ssr_smi_if smi_if_inst ();
  ssr_host ssr_host_inst (.core_clk, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .smi(smi_if_inst));
  ssr_dev ssr_dev_inst (.core_clk, .reset, .smi(smi_if_inst),
    .rx_err_evt(ev[2]), .mlt3_err_evt(ev[1]), .low_snr_evt(ev[0]),
    .energy_loss, .tdi_pin,
    .rx_sym_bit4(1'b0), .link_drop, .pol_invert, .pair_swap, .port_mirror,
    .bypass_4b5b, .tx_sym_bit4, .receive_error_pin, .strap_reset);
  ssr_props ssr_props_inst (.core_clk, .reset, .mdc(smi_if_inst.mdc),
    .host_mdio_o(smi_if_inst.host_mdio_o), .mdio_in(smi_if_inst.mdio_in),
    .host_mdio_oe(smi_if_inst.host_mdio_oe),
    .dev_mdio_o(smi_if_inst.dev_mdio_o),
    .dev_mdio_oe(smi_if_inst.dev_mdio_oe));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // APB transfer; pready and read data taken at one rising edge
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
    @(posedge core_clk);
    paddr <= {24'h0, a};
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One management frame, busy polled with a cap
  task automatic mio(logic w, logic [4:0] r, logic [15:0] d);
    int n = 0;
    apb(HOFF_CMD, 1'b1, {10'h0, w, r, d});
    do begin
      apb(HOFF_STATUS, 1'b0, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 600);
    apb(HOFF_RDATA, 1'b0, 0);
  endtask
  task automatic rdv(logic [4:0] r, logic [15:0] e, string n);
    mio(1'b0, r, 16'h0);
    chk(n, {16'h0, e}, {16'h0, rd[15:0]});
  endtask
  task automatic t_strap();
    mio(1'b1, OFF_STRAP3, 16'hffff);
    rdv(OFF_STRAP3, 16'h007f, "strap3");
    chk("early", 0, pol_invert);
    tdi_pin <= 1'b1;
    mio(1'b1, OFF_STRAP1, 16'h8000);
    chk("swaps", 4'hf, {pol_invert, pair_swap, port_mirror, bypass_4b5b});
    chk("txbit4", 1, tx_sym_bit4);
    chk("srst", 1, srst_n);
  endtask
  task automatic t_drop();
    int k = 0;
    int e = 0;
    @(posedge core_clk) energy_loss <= 1'b1;
    repeat (4) @(negedge core_clk) k += link_drop;
    @(posedge core_clk) energy_loss <= 1'b0;
    chk("energy", 3, k);
    // Burst of 64 per source; any window split leaves one part >= 32
    for (int s = 0; s < 3; s++) begin
      k = 0;
      for (int i = 0; i < 68; i++) begin
        @(posedge core_clk) ev <= (i < 64) ? 3'h4 >> s : 3'h0;
        @(negedge core_clk) k += link_drop;
        e += receive_error_pin;
      end
      chk("fld", 1, k > 0);
    end
    chk("rxpin", 0, e);
  endtask
  task automatic t_ind();
    mio(1'b1, OFF_IACR, 16'hffff);
    rdv(OFF_IACR, 16'hc01f, "iacr");
    mio(1'b1, OFF_IACR, 16'h001f);
    mio(1'b1, OFF_IADR, 16'h0005);
    mio(1'b1, OFF_IACR, 16'h801f);
    mio(1'b1, OFF_IADR, 16'haaaa);
    mio(1'b1, OFF_IADR, 16'hbbbb);
    rdv(OFF_IADR, 16'h0000, "fn10 rd");
    mio(1'b1, OFF_IACR, 16'h001f);
    rdv(OFF_IADR, 16'h0008, "ptr inc");
    mio(1'b1, OFF_IADR, 16'h0005);
    mio(1'b1, OFF_IACR, 16'hc01f);
    rdv(OFF_IADR, 16'haaaa, "fn11 rd");
    rdv(OFF_IADR, 16'haaaa, "fn11 rd2");
    mio(1'b1, OFF_IACR, 16'h401f);
    mio(1'b1, OFF_IADR, 16'h1234);
    rdv(OFF_IADR, 16'h1234, "fn01");
    mio(1'b1, OFF_IACR, 16'h001e);
    rdv(OFF_IADR, 16'h0000, "bad target");
    mio(1'b1, OFF_IACR, 16'h001f);
    rdv(OFF_IADR, 16'h0005, "ptr kept");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog well past the expected frame count
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    t_strap();
    t_drop();
    t_ind();
    give_verdict();
  end
endmodule
